/* File: src/dacrm_regfile.sv */
// Volatile register file of a one- or two-channel voltage-output DAC.
//
// Overview of operation
// R1 - Reads of valid addresses return unimplemented bits as zero.
// R2 - Any read or write to a reserved address raises the command error.
// R3 - Reserved locations hold all ones sized to the resolution.
// R4 - After a reserved read raises the error, returned data is all zeros.
// R5 - Host raises chip select to recover; device then clears its error state.
// R6 - Reset loads each output code with mid scale for the resolution.
// R7 - Reset clears reference and power-down words; gain/status becomes 0080h.
// R8 - Output codes are 8, 10 or 12 bits, right justified.
// R9 - Reference word at 08h holds two select bits per channel.
// R10 - Reference codes: pin buffered, pin unbuffered, band gap, supply.
// R11 - Band gap selection keeps the reference pin driven in power-down.
// R12 - Host should pair supply reference with power-down for lowest current.
// R13 - Power-down word holds two bits per channel, same layout as reference.
// R14 - Power-down codes: open, 100k pull-down, 1k pull-down, normal.
// R15 - Gain bits at 8 and 9 select double gain per channel.
// R16 - Reset-event flag at bit 7 is set by reset, cleared by reading.
// R17 - Every address holds a 16-bit word; 00h through 1Fh are decoded.
// R18 - Writes to unimplemented bits are dropped and those bits stay zero.
module dacrm_regfile
    import dacrm_pkg::*;
#(
    parameter int RES_BITS = 12, // Output code resolution: 8, 10 or 12.
    parameter int NUM_CHAN = 2 // Channel count: 1 or 2.
) (
    input wire logic clk_sys, // System clock.
    input wire logic rstn, // Synchronous reset, active low (power-on/brown-out).
    input wire logic cs_n, // Serial chip select, active low.
    input wire logic cmd_valid, // Register command present.
    input dacrm_cmd_type cmd, // Command: write, address, write data.
    output logic cmd_ready, // Command can be taken.
    output logic rsp_valid, // One-cycle answer strobe.
    output logic [DATA_W-1:0] rsp_data, // Read data.
    output logic rsp_error, // Answer belongs to a refused access.
    output logic command_error_flag, // Command error held until chip select rises.
    output logic reset_event_flag, // Reset-event status bit.
    output dacrm_chan_out_type chan_out [NUM_CHAN] // Decoded channel controls.
);

    // ------------------------------------------------------------------
    // Elaboration checks and derived constants
    // ------------------------------------------------------------------
    if (!(RES_BITS == 8 || RES_BITS == 10 || RES_BITS == 12)) begin : g_bad_res
        $error("RES_BITS must be 8, 10 or 12.");
    end
    if (!(NUM_CHAN == 1 || NUM_CHAN == 2)) begin : g_bad_chan
        $error("NUM_CHAN must be 1 or 2.");
    end

    localparam logic [CODE_W-1:0] MID_CODE = (RES_BITS == 8) ? MID_CODE_8 :
        (RES_BITS == 10) ? MID_CODE_10 : MID_CODE_12;
    // Content of reserved locations; it is never returned, because such a read is refused.
    localparam logic [CODE_W-1:0] RSV_FILL = (RES_BITS == 8) ? RSV_FILL_8 :
        (RES_BITS == 10) ? RSV_FILL_10 : RSV_FILL_12; // R3
    localparam logic [CODE_W-1:0] CODE_MASK = RSV_FILL;
    localparam logic [2*SEL_W-1:0] SEL_MASK = (NUM_CHAN == 2) ? 4'hF : 4'h3;
    localparam logic [1:0] GAIN_MASK = (NUM_CHAN == 2) ? 2'h3 : 2'h1;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [CODE_W-1:0] code_q [2];
    logic [CODE_W-1:0] code_d [2];
    logic [2*SEL_W-1:0] ref_sel_q;
    logic [2*SEL_W-1:0] ref_sel_d;
    logic [2*SEL_W-1:0] pd_sel_q;
    logic [2*SEL_W-1:0] pd_sel_d;
    logic [1:0] gain_q;
    logic [1:0] gain_d;
    logic reset_flag_q;
    logic reset_flag_d;
    logic err_q;
    logic err_d;
    logic rsp_valid_q;
    logic rsp_valid_d;
    logic rsp_error_q;
    logic rsp_error_d;
    logic [DATA_W-1:0] rsp_data_q;
    logic [DATA_W-1:0] rsp_data_d;
    logic take;
    logic addr_ok;
    logic [DATA_W-1:0] rd_word;

    assign take = cmd_valid && !err_q;

    // ------------------------------------------------------------------
    // Address decode and read mux
    // ------------------------------------------------------------------
    always_comb begin
        addr_ok = 1'b0;
        rd_word = 16'h0000;
        case (cmd.addr) // R17
            ADDR_CHAN0_CODE: begin
                addr_ok = 1'b1;
                rd_word = {4'h0, code_q[0]}; // R1
            end
            ADDR_CHAN1_CODE: begin
                addr_ok = (NUM_CHAN == 2);
                rd_word = {4'h0, code_q[1]}; // R1
            end
            ADDR_REF_SELECT: begin
                addr_ok = 1'b1;
                rd_word = {12'h000, ref_sel_q}; // R9
            end
            ADDR_POWER_DOWN: begin
                addr_ok = 1'b1;
                rd_word = {12'h000, pd_sel_q}; // R13
            end
            ADDR_GAIN_STATUS: begin
                addr_ok = 1'b1;
                rd_word = {6'h00, gain_q, reset_flag_q, 7'h00}; // R15
            end
            default: begin
                addr_ok = 1'b0;
                rd_word = 16'h0000;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Command handling
    // ------------------------------------------------------------------
    always_comb begin
        code_d = code_q;
        ref_sel_d = ref_sel_q;
        pd_sel_d = pd_sel_q;
        gain_d = gain_q;
        reset_flag_d = reset_flag_q;
        err_d = err_q;
        rsp_valid_d = 1'b0;
        rsp_error_d = 1'b0;
        rsp_data_d = 16'h0000;
        // Raising chip select resets the serial state; a new error in the same cycle still wins.
        if (cs_n) begin
            err_d = 1'b0; // R5
        end
        if (take) begin
            rsp_valid_d = 1'b1;
            if (!addr_ok) begin
                err_d = 1'b1; // R2
                rsp_error_d = 1'b1;
                rsp_data_d = ERROR_READ_DATA; // R4
            end else if (cmd.write) begin
                case (cmd.addr) // R18
                    ADDR_CHAN0_CODE: code_d[0] = cmd.wdata[CODE_W-1:0] & CODE_MASK; // R8
                    ADDR_CHAN1_CODE: code_d[1] = cmd.wdata[CODE_W-1:0] & CODE_MASK; // R8
                    ADDR_REF_SELECT: ref_sel_d = cmd.wdata[2*SEL_W-1:0] & SEL_MASK; // R9
                    ADDR_POWER_DOWN: pd_sel_d = cmd.wdata[2*SEL_W-1:0] & SEL_MASK; // R13
                    ADDR_GAIN_STATUS: gain_d = cmd.wdata[GAIN1_POS:GAIN0_POS] & GAIN_MASK;
                    default: gain_d = gain_q;
                endcase
            end else begin
                rsp_data_d = rd_word; // R1
                if (cmd.addr == ADDR_GAIN_STATUS) begin
                    reset_flag_d = 1'b0; // R16
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            code_q[0] <= MID_CODE; // R6
            code_q[1] <= (NUM_CHAN == 2) ? MID_CODE : 12'h000; // R6
            ref_sel_q <= REF_SELECT_RST[2*SEL_W-1:0]; // R7
            pd_sel_q <= POWER_DOWN_RST[2*SEL_W-1:0]; // R7
            gain_q <= GAIN_STATUS_RST[GAIN1_POS:GAIN0_POS]; // R7
            reset_flag_q <= GAIN_STATUS_RST[RESET_FLAG_POS]; // R16
            err_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_error_q <= 1'b0;
            rsp_data_q <= 16'h0000;
        end else begin
            code_q <= code_d;
            ref_sel_q <= ref_sel_d;
            pd_sel_q <= pd_sel_d;
            gain_q <= gain_d;
            reset_flag_q <= reset_flag_d;
            err_q <= err_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_error_q <= rsp_error_d;
            rsp_data_q <= rsp_data_d;
        end
    end

    assign cmd_ready = !err_q; // R5
    assign rsp_valid = rsp_valid_q;
    assign rsp_error = rsp_error_q;
    assign rsp_data = rsp_data_q;
    assign command_error_flag = err_q;
    assign reset_event_flag = reset_flag_q;

    // ------------------------------------------------------------------
    // Channel decoders
    // ------------------------------------------------------------------
    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
        dacrm_chan_decode u_decode (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .code(code_q[ch]),
            .reference_source_code(ref_sel_q[ch*SEL_W +: SEL_W]), // R9
            .power_down_code(pd_sel_q[ch*SEL_W +: SEL_W]), // R13
            .gain_double(gain_q[ch]), // R15
            .chan_out(chan_out[ch])
        );
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    reserved_error_a: assert property ( // R2
        cmd_valid && cmd_ready && !addr_ok |=> rsp_valid && rsp_error && command_error_flag)
        else $error("Reserved access did not raise the command error.");

    error_zero_data_a: assert property ( // R4
        rsp_valid && rsp_error |-> rsp_data == 16'h0000)
        else $error("Refused read returned nonzero data.");

    // Implemented bits of the addressed word, built apart from the read mux so that
    // a slip in the mux cannot hide itself.
    logic [DATA_W-1:0] impl_mask;

    always_comb begin
        impl_mask = 16'h0000;
        if (cmd.addr == ADDR_CHAN0_CODE || cmd.addr == ADDR_CHAN1_CODE) begin
            impl_mask = {4'h0, CODE_MASK};
        end else if (cmd.addr == ADDR_REF_SELECT || cmd.addr == ADDR_POWER_DOWN) begin
            impl_mask = {12'h000, SEL_MASK};
        end else if (cmd.addr == ADDR_GAIN_STATUS) begin
            impl_mask = {6'h00, GAIN_MASK, 1'b1, 7'h00};
        end
    end

    unimpl_bits_zero_a: assert property ( // R1
        take && !cmd.write && addr_ok |=> (rsp_data & ~$past(impl_mask)) == 16'h0000)
        else $error("Unimplemented bits read back nonzero.");

    error_hold_a: assert property ( // R5
        command_error_flag && !cs_n |=> command_error_flag && !cmd_ready)
        else $error("Command error dropped while chip select stayed low.");

    error_release_a: assert property ( // R5
        command_error_flag && cs_n |=> !command_error_flag && cmd_ready)
        else $error("Chip select high did not clear the command error.");

    status_read_clear_a: assert property ( // R16
        take && !cmd.write && cmd.addr == ADDR_GAIN_STATUS
        |=> rsp_valid && rsp_data[RESET_FLAG_POS] == $past(reset_event_flag) && !reset_event_flag)
        else $error("Status read did not return and then clear the reset flag.");

    reset_defaults_a: assert property ( // R7
        $rose(rstn) |-> reset_event_flag && ref_sel_q == 4'h0 && pd_sel_q == 4'h0
            && gain_q == 2'h0 && !command_error_flag)
        else $error("Configuration words missed their reset values.");

    reset_midscale_a: assert property ( // R6
        $rose(rstn) |-> code_q[0] == MID_CODE ##1 chan_out[0].output_code_bits == MID_CODE)
        else $error("Output code did not reset to mid scale.");

    write_mask_a: assert property ( // R18
        take && cmd.write && cmd.addr == ADDR_REF_SELECT
        |=> ref_sel_q == ($past(cmd.wdata[3:0]) & SEL_MASK) && rsp_data == 16'h0000)
        else $error("Reference write did not drop unimplemented bits.");

    code_write_a: assert property ( // R8
        take && cmd.write && cmd.addr == ADDR_CHAN0_CODE
        |=> ##1 chan_out[0].output_code_bits == ($past(cmd.wdata[11:0], 2) & CODE_MASK))
        else $error("Channel code write not right justified to the resolution.");

    gain_write_a: assert property ( // R15
        take && cmd.write && cmd.addr == ADDR_GAIN_STATUS
        |=> gain_q == ($past(cmd.wdata[GAIN1_POS:GAIN0_POS]) & GAIN_MASK)
            && reset_event_flag == $past(reset_event_flag))
        else $error("Gain write did not land or disturbed the reset flag.");

    pd_write_a: assert property ( // R13
        take && cmd.write && cmd.addr == ADDR_POWER_DOWN
        |=> pd_sel_q == ($past(cmd.wdata[2*SEL_W-1:0]) & SEL_MASK))
        else $error("Power-down write did not land in the selector bits.");

    refused_silent_a: assert property ( // R5
        command_error_flag |=> !rsp_valid)
        else $error("A command was answered while the command error was pending.");

endmodule : dacrm_regfile

/* File: src/dacrm_pkg.sv */
// Package of constants and carrier types for the volatile DAC register map.
package dacrm_pkg;

    // ------------------------------------------------------------------
    // Address map (one 16-bit word per address, 00h to 1Fh decoded)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int CODE_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_CHAN0_CODE = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_CHAN1_CODE = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_REF_SELECT = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_POWER_DOWN = 5'h09;
    localparam logic [ADDR_W-1:0] ADDR_GAIN_STATUS = 5'h0A;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SEL_W = 2;
    localparam int GAIN0_POS = 8;
    localparam int GAIN1_POS = 9;
    localparam int RESET_FLAG_POS = 7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [CODE_W-1:0] MID_CODE_8 = 12'h07F;
    localparam logic [CODE_W-1:0] MID_CODE_10 = 12'h1FF;
    localparam logic [CODE_W-1:0] MID_CODE_12 = 12'h7FF;
    localparam logic [CODE_W-1:0] RSV_FILL_8 = 12'h0FF;
    localparam logic [CODE_W-1:0] RSV_FILL_10 = 12'h3FF;
    localparam logic [CODE_W-1:0] RSV_FILL_12 = 12'hFFF;
    localparam logic [DATA_W-1:0] REF_SELECT_RST = 16'h0000;
    localparam logic [DATA_W-1:0] POWER_DOWN_RST = 16'h0000;
    localparam logic [DATA_W-1:0] GAIN_STATUS_RST = 16'h0080;
    localparam logic [DATA_W-1:0] ERROR_READ_DATA = 16'h0000;

    // ------------------------------------------------------------------
    // Selector encodings
    // ------------------------------------------------------------------
    localparam logic [SEL_W-1:0] REF_PIN_BUFFERED = 2'h3;
    localparam logic [SEL_W-1:0] REF_PIN_UNBUFFERED = 2'h2;
    localparam logic [SEL_W-1:0] REF_BANDGAP = 2'h1;
    localparam logic [SEL_W-1:0] REF_SUPPLY = 2'h0;
    localparam logic [SEL_W-1:0] PD_OPEN = 2'h3;
    localparam logic [SEL_W-1:0] PD_100K = 2'h2;
    localparam logic [SEL_W-1:0] PD_1K = 2'h1;
    localparam logic [SEL_W-1:0] PD_NORMAL = 2'h0;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dacrm_cmd_type;

    typedef struct packed {
        logic [CODE_W-1:0] output_code_bits;
        logic ref_from_pin;
        logic ref_from_bandgap;
        logic ref_from_supply;
        logic ref_buffer_en;
        logic ref_pin_driven;
        logic out_open;
        logic out_pull_100k;
        logic out_pull_1k;
        logic out_active;
        logic gain_double;
    } dacrm_chan_out_type;

endpackage : dacrm_pkg

/* File: src/dacrm_chan_decode.sv */
// Per-channel decode of code, reference, power-down and gain into control levels.
module dacrm_chan_decode
    import dacrm_pkg::*;
(
    input wire logic clk_sys, // System clock.
    input wire logic rstn, // Synchronous reset, active low.
    input wire logic [CODE_W-1:0] code, // Right-justified output code.
    input wire logic [SEL_W-1:0] reference_source_code, // Reference selector.
    input wire logic [SEL_W-1:0] power_down_code, // Power-down selector.
    input wire logic gain_double, // High for double gain.
    output dacrm_chan_out_type chan_out // Registered channel controls.
);

    dacrm_chan_out_type out_d;
    dacrm_chan_out_type out_q;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    always_comb begin
        out_d = '0;
        out_d.output_code_bits = code; // R8
        out_d.gain_double = gain_double; // R15
        case (reference_source_code) // R10
            REF_PIN_BUFFERED: begin
                out_d.ref_from_pin = 1'b1;
                out_d.ref_buffer_en = 1'b1;
            end
            REF_PIN_UNBUFFERED: begin
                out_d.ref_from_pin = 1'b1;
            end
            REF_BANDGAP: begin
                out_d.ref_from_bandgap = 1'b1;
                out_d.ref_buffer_en = 1'b1;
            end
            default: begin
                out_d.ref_from_supply = 1'b1;
            end
        endcase
        // The band gap keeps the reference pin driven whatever the power-down state.
        out_d.ref_pin_driven = (reference_source_code == REF_BANDGAP); // R11
        case (power_down_code) // R14
            PD_OPEN: out_d.out_open = 1'b1;
            PD_100K: out_d.out_pull_100k = 1'b1;
            PD_1K: out_d.out_pull_1k = 1'b1;
            default: out_d.out_active = 1'b1;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

    assign chan_out = out_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    bandgap_drive_a: assert property ( // R11
        reference_source_code == REF_BANDGAP && power_down_code != PD_NORMAL
        |=> chan_out.ref_pin_driven && chan_out.ref_buffer_en && !chan_out.out_active)
        else $error("Band gap selection did not keep the reference pin driven.");

    pd_decode_a: assert property ( // R14
        ##1 $past(power_down_code) == PD_100K |-> chan_out.out_pull_100k
            && !chan_out.out_pull_1k && !chan_out.out_open && !chan_out.out_active)
        else $error("Power-down selector decoded to the wrong load.");

    ref_decode_a: assert property ( // R10
        reference_source_code == REF_PIN_UNBUFFERED
        |=> chan_out.ref_from_pin && !chan_out.ref_buffer_en && !chan_out.ref_pin_driven)
        else $error("Unbuffered pin selection decoded wrongly.");

endmodule : dacrm_chan_decode

/* File: bench/dacrm_host_model.sv */
// Host-side model that issues register commands and recovers from errors.
module dacrm_host_model
    import dacrm_pkg::*;
(
    input wire logic clk_sys, // System clock.
    input wire logic cmd_ready, // Device can take a command.
    output logic cs_n, // Chip select, active low.
    output logic cmd_valid, // Command present.
    output dacrm_cmd_type cmd // Command word.
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cs_n = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
    end
    // A request is held until an edge that sees the device ready.
    task automatic send(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output bit ok);
        int n;
        cmd_valid <= 1'b1;
        cmd <= '{write: w, addr: a, wdata: d};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (cmd_ready !== 1'b1 && n < 40);
        ok = (cmd_ready === 1'b1);
    endtask : send
    // Released command lines show inverted data so a stale word is never reused.
    task automatic idle();
        cmd_valid <= 1'b0;
        cmd <= ~cmd;
        @(posedge clk_sys);
    endtask : idle
    task automatic recover();
        cs_n <= 1'b1;
        @(posedge clk_sys);
        cs_n <= 1'b0;
        @(posedge clk_sys);
    endtask : recover
endmodule : dacrm_host_model

/* File: bench/dac_volatile_register_map_test.sv */
// Self-checking bench for the volatile DAC register map.
module dac_volatile_register_map_test
    import dacrm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADR [5] = '{5'h00, 5'h01, 5'h08, 5'h09, 5'h0A};
    localparam logic [DATA_W-1:0] MSK [5] = '{16'h0FFF, 16'h0FFF, 16'h000F, 16'h000F, 16'h0300};
    logic clk_sys;
    logic rstn;
    logic cs_n;
    logic cmd_valid;
    dacrm_cmd_type cmd;
    logic cmd_ready;
    logic rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    logic rsp_error;
    logic command_error_flag;
    logic reset_event_flag;
    dacrm_chan_out_type chan_out [2];
    int n_errors = 0;
    int check_count = 0;
    logic [DATA_W:0] exp_q [$];
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    dacrm_regfile #(.RES_BITS(12), .NUM_CHAN(2)) i_dacrm_regfile (
        .clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_error(rsp_error), .command_error_flag(command_error_flag),
        .reset_event_flag(reset_event_flag), .chan_out(chan_out));
    dacrm_host_model i_dacrm_host_model (
        .clk_sys(clk_sys), .cmd_ready(cmd_ready), .cs_n(cs_n),
        .cmd_valid(cmd_valid), .cmd(cmd));
    // ------------------------------------------------------------------
    // Checking and driving tasks
    // ------------------------------------------------------------------
    task automatic check_val(input string name, input logic [DATA_W:0] exp,
                             input logic [DATA_W:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    // Answers are matched in order against the notes left by the driver.
    always @(posedge clk_sys) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("[ERR] answer expected none seen %h", rsp_data);
            end else
                check_val("answer", exp_q.pop_front(), {rsp_error, rsp_data});
        end
    end
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic [DATA_W:0] exp);
        bit ok;
        exp_q.push_back(exp);
        i_dacrm_host_model.send(w, a, d, ok);
        if (!ok) begin
            n_errors++;
            $display("[ERR] command taken expected 1 seen 0");
            results();
        end
    endtask : acc
    task automatic drain();
        int n;
        i_dacrm_host_model.idle();
        n = 0;
        while (exp_q.size() != 0 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        if (exp_q.size() != 0) begin
            n_errors++;
            $display("[ERR] pending answers expected 0 seen %0d", exp_q.size());
            results();
        end
        repeat (2) @(posedge clk_sys);
    endtask : drain
    task automatic do_reset();
        rstn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
    endtask : do_reset
    task automatic chk_defaults();
        check_val("reset flag", 17'h1, {16'h0, reset_event_flag});
        acc(1'b0, 5'h00, 16'h0, 17'h07FF);
        acc(1'b0, 5'h01, 16'h0, 17'h07FF);
        acc(1'b0, 5'h08, 16'h0, 17'h0000);
        acc(1'b0, 5'h09, 16'h0, 17'h0000);
        acc(1'b0, 5'h0A, 16'h0, 17'h0080);
        acc(1'b0, 5'h0A, 16'h0, 17'h0000);
        drain();
        check_val("reset flag", 17'h0, {16'h0, reset_event_flag});
        check_val("out active", 17'h1, {16'h0, chan_out[1].out_active});
        check_val("chan code", 17'h07FF, {5'h0, chan_out[0].output_code_bits});
        $display("test defaults done");
    endtask : chk_defaults
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [DATA_W-1:0] v;
        int r;
        int p;
        dacrm_chan_out_type co;
        do_reset();
        void'($urandom(96139));
        chk_defaults();
        for (int i = 0; i < 5; i++) begin
            acc(1'b1, ADR[i], 16'hFFFF, 17'h0);
            acc(1'b0, ADR[i], 16'h0, {1'b0, MSK[i]});
        end
        repeat (6) begin
            v = 16'($urandom());
            acc(1'b1, 5'h00, v, 17'h0);
            acc(1'b0, 5'h00, 16'h0, {5'h0, v[11:0]});
        end
        drain();
        $display("test bit fields done");
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, 5'h08, 16'(k | ((3 - k) << 2)), 17'h0);
            acc(1'b1, 5'h09, 16'((3 - k) | (k << 2)), 17'h0);
            acc(1'b1, 5'h0A, 16'(k << 8), 17'h0);
            drain();
            for (int c = 0; c < 2; c++) begin
                r = c ? 3 - k : k;
                p = c ? k : 3 - k;
                co = chan_out[c];
                check_val("decode", {8'h0, r[1], r == 1, r == 0, r[0], p == 3, p == 2,
                    p == 1, p == 0, k[c]}, {8'h0, co.ref_from_pin, co.ref_from_bandgap,
                    co.ref_from_supply, co.ref_buffer_en, co.out_open, co.out_pull_100k,
                    co.out_pull_1k, co.out_active, co.gain_double});
                check_val("pin driven", {16'h0, r == 1}, {16'h0, co.ref_pin_driven});
            end
        end
        $display("test decode done");
        for (int a = 0; a < 32; a++) begin
            if (a inside {[2:7], [11:31]}) begin
                acc(a[0], 5'(a), 16'hFFFF, 17'h10000);
                drain();
                check_val("error flag", 17'h1, {16'h0, command_error_flag});
                check_val("ready", 17'h0, {16'h0, cmd_ready});
                i_dacrm_host_model.recover();
                check_val("error flag", 17'h0, {16'h0, command_error_flag});
            end
        end
        acc(1'b0, 5'h01, 16'h0, 17'h0FFF);
        drain();
        $display("test reserved done");
        do_reset();
        chk_defaults();
        results();
    end
endmodule : dac_volatile_register_map_test
